// ==== rtl/dmau_top.sv ====
`timescale 1ns/1ps
module dmau_top (
  // Clock and control
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // Decoder request
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic req_rd,
  input wire logic req_wr,
  input wire logic access_bit,
  input wire logic [7:0] operand,
  input wire logic [11:0] full_addr,
  input wire logic [7:0] literal,
  input wire logic [7:0] working_reg,
  input wire logic [7:0] wdata,
  // Data RAM
  output logic [11:0] ram_addr,
  output logic ram_rd_en,
  output logic ram_wr_en,
  output logic [7:0] ram_wdata,
  input wire logic [7:0] ram_rdata,
  // Read result and state
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic [7:0] bank_select_reg
);

  typedef struct packed {
    logic [3:0] bank_select;
    logic [11:0] ram_addr;
    logic ram_rd;
    logic ram_wr;
    logic [7:0] ram_wdata;
    logic s1_rd;
    logic s1_ram;
    logic [7:0] s1_val;
    logic s2_rd;
    logic s2_ram;
    logic [7:0] s2_val;
    logic rd_valid;
    logic [7:0] rd_data;
  } dmau_top_s;

  dmau_top_s r;
  dmau_top_s n;

  dmau_pkg::dmau_ptr_cmd_e ptr_cmd [dmau_pkg::NUM_PTR];
  logic ptr_wr_hi [dmau_pkg::NUM_PTR];
  logic ptr_wr_lo [dmau_pkg::NUM_PTR];
  logic [11:0] ptr_val [dmau_pkg::NUM_PTR];

  logic take;
  logic [11:0] ea;
  logic [11:0] fa;
  logic hit;
  logic [1:0] hsel;
  logic [2:0] hmode;
  logic self_port;
  logic c_ram;
  logic c_unimpl;
  logic c_ptrwr;

  dmau_ptr_if pif [dmau_pkg::NUM_PTR] ();

  for (genvar g = 0; g < dmau_pkg::NUM_PTR; g++) begin : g_ptr
    assign pif[g].cmd = ptr_cmd[g];
    assign pif[g].wr_hi = ptr_wr_hi[g];
    assign pif[g].wr_lo = ptr_wr_lo[g];
    assign pif[g].wdata = wdata;
    assign ptr_val[g] = pif[g].value;
    dmau_ptr u_ptr (
      .core_clk(core_clk),
      .srst(srst),
      .ce(ce),
      .pif(pif[g])
    );
  end

  function automatic logic is_port(input logic [11:0] a);
    logic res;
    res = 1'b0;
    for (int i = 0; i < dmau_pkg::NUM_PTR; i++) begin
      for (int k = 0; k < dmau_pkg::NUM_PORT; k++) begin
        if (a == dmau_pkg::PTR_BASE[i] - dmau_pkg::PORT_OFS[k]) begin
          res = 1'b1;
        end
      end
    end
    return res;
  endfunction : is_port

  assign take = req_valid && ce;

  always_comb begin
    n = r;
    n.ram_rd = 1'b0;
    n.ram_wr = 1'b0;
    n.s1_rd = 1'b0;
    n.s1_ram = 1'b0;
    n.s1_val = 8'h00;
    n.s2_rd = r.s1_rd;
    n.s2_ram = r.s1_ram;
    n.s2_val = r.s1_val;
    n.rd_valid = r.s2_rd;
    n.rd_data = r.s2_ram ? ram_rdata : r.s2_val;
    c_ram = 1'b0;
    c_unimpl = 1'b0;
    c_ptrwr = 1'b0;
    for (int i = 0; i < dmau_pkg::NUM_PTR; i++) begin
      ptr_cmd[i] = dmau_pkg::PTR_HOLD;
      ptr_wr_hi[i] = 1'b0;
      ptr_wr_lo[i] = 1'b0;
    end
    // Effective operand address
    if (req_kind == dmau_pkg::REQ_FULL) begin
      ea = full_addr;
    end else if (access_bit) begin
      ea = {r.bank_select, operand};
    end else if (!operand[7]) begin
      ea = {dmau_pkg::ACC_LOW_BANK, operand};
    end else begin
      ea = {dmau_pkg::ACC_HIGH_BANK, operand};
    end
    // Port decode: five locations per pointer
    hit = 1'b0;
    hsel = 2'h0;
    hmode = dmau_pkg::PORT_PLAIN;
    for (int i = 0; i < dmau_pkg::NUM_PTR; i++) begin
      for (int k = 0; k < dmau_pkg::NUM_PORT; k++) begin
        if (ea == dmau_pkg::PTR_BASE[i] - dmau_pkg::PORT_OFS[k]) begin
          hit = 1'b1;
          hsel = 2'(i);
          hmode = 3'(k);
        end
      end
    end
    fa = ea;
    if (hit) begin
      case (hmode)
        dmau_pkg::PORT_PREINC: fa = ptr_val[hsel] + 12'h001;
        dmau_pkg::PORT_OFFSET: fa = ptr_val[hsel] + {{4{working_reg[7]}}, working_reg};
        default: fa = ptr_val[hsel];
      endcase
    end
    self_port = hit && is_port(fa);
    if (take && req_kind == dmau_pkg::REQ_LOAD_BANK) begin
      n.bank_select = literal[3:0];
    end else if (take && (req_rd || req_wr)) begin
      n.s1_rd = req_rd;
      if (self_port) begin
        n.s1_val = 8'h00;
      end else if (fa == dmau_pkg::BANK_SEL_ADDR) begin
        n.s1_val = {4'h0, r.bank_select};
        if (req_wr) begin
          n.bank_select = wdata[3:0];
        end
      end else if (!dmau_pkg::IMPL_BANKS[fa[11:8]]) begin
        c_unimpl = 1'b1;
      end else begin
        c_ram = 1'b1;
        for (int j = 0; j < dmau_pkg::NUM_PTR; j++) begin
          if (fa == dmau_pkg::PTR_BASE[j] - dmau_pkg::PTR_HI_OFS) begin
            c_ram = 1'b0;
            n.s1_val = {4'h0, ptr_val[j][11:8]};
            ptr_wr_hi[j] = req_wr;
          end
          if (fa == dmau_pkg::PTR_BASE[j] - dmau_pkg::PTR_LO_OFS) begin
            c_ram = 1'b0;
            n.s1_val = ptr_val[j][7:0];
            ptr_wr_lo[j] = req_wr;
          end
        end
        if (c_ram) begin
          n.ram_addr = fa;
          n.ram_rd = req_rd;
          n.ram_wr = req_wr;
          n.ram_wdata = wdata;
          n.s1_ram = req_rd;
        end
      end
      // Pointer steps even when the target is itself a port
      if (hit) begin
        case (hmode)
          dmau_pkg::PORT_POSTDEC: ptr_cmd[hsel] = dmau_pkg::PTR_DEC;
          dmau_pkg::PORT_POSTINC: ptr_cmd[hsel] = dmau_pkg::PTR_INC;
          dmau_pkg::PORT_PREINC: ptr_cmd[hsel] = dmau_pkg::PTR_INC;
          default: ptr_cmd[hsel] = dmau_pkg::PTR_HOLD;
        endcase
      end
    end
    for (int j = 0; j < dmau_pkg::NUM_PTR; j++) begin
      if (ptr_wr_hi[j] || ptr_wr_lo[j]) begin
        c_ptrwr = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      r <= '0;
      r.bank_select <= dmau_pkg::BSR_RESET;
    end else if (ce) begin
      r <= n;
    end
  end

  assign ram_addr = r.ram_addr;
  assign ram_rd_en = r.ram_rd;
  assign ram_wr_en = r.ram_wr;
  assign ram_wdata = r.ram_wdata;
  assign rd_data = r.rd_data;
  assign rd_valid = r.rd_valid;
  assign bank_select_reg = {4'h0, r.bank_select};

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_unimpl_rd;
    take && req_rd && c_unimpl ##1 ce ##1 ce;
  endsequence

  sequence s_self_rd;
    take && req_rd && self_port ##1 ce ##1 ce;
  endsequence

  a_bsr_upper_zero: assert property (bank_select_reg[7:4] == 4'h0)
    else $error("bank select upper bits not zero");
  a_load_bank_lit: assert property (take && req_kind == dmau_pkg::REQ_LOAD_BANK
    |=> bank_select_reg == {4'h0, $past(literal[3:0])})
    else $error("load bank did not take literal");
  a_access_low_map: assert property (take && req_kind == dmau_pkg::REQ_DIRECT
    && !access_bit && !operand[7] && req_rd
    |=> ram_rd_en && ram_addr == {4'h0, $past(operand)})
    else $error("low access half mapped wrong");
  // Port hits go through a pointer, so only plain operands map here
  a_access_high_map: assert property (take && req_kind == dmau_pkg::REQ_DIRECT
    && !access_bit && operand[7] && c_ram && !hit
    |=> ram_addr == {4'hf, $past(operand)})
    else $error("high access half mapped wrong");
  a_bank_direct_addr: assert property (take && req_kind == dmau_pkg::REQ_DIRECT
    && access_bit && c_ram && !hit |=> ram_addr[11:8] == $past(r.bank_select))
    else $error("bank select not used for direct address");
  a_full_addr_used: assert property (take && req_kind == dmau_pkg::REQ_FULL
    && c_ram && !hit |=> ram_addr == $past(full_addr))
    else $error("full address not used");
  a_unimpl_read_zero: assert property (s_unimpl_rd |=> rd_valid && rd_data == 8'h00)
    else $error("unimplemented bank read not zero");
  a_unimpl_no_ram: assert property (take && c_unimpl |=> !ram_rd_en && !ram_wr_en)
    else $error("unimplemented bank reached RAM");
  a_self_port_zero: assert property (s_self_rd |=> rd_valid && rd_data == 8'h00)
    else $error("self port read not zero");
  a_self_port_nop: assert property (take && self_port |=> !ram_wr_en && !ram_rd_en)
    else $error("self port write reached RAM");
  a_postinc_step: assert property (take && hit && hsel == 2'h0 && !c_ptrwr
    && (req_rd || req_wr) && hmode == dmau_pkg::PORT_POSTINC
    |=> ptr_val[0] == $past(ptr_val[0]) + 12'h001)
    else $error("post increment wrong");
  a_offset_hold: assert property (take && hit && hmode == dmau_pkg::PORT_OFFSET
    && !c_ptrwr && (req_rd || req_wr) && hsel == 2'h0 |=> ptr_val[0] == $past(ptr_val[0]))
    else $error("offset port changed pointer");

endmodule : dmau_top

// ==== rtl/dmau_pkg.sv ====
package dmau_pkg;

  localparam int ADDR_W = 12;
  localparam int NUM_PTR = 3;
  localparam int NUM_PORT = 5;

  // Access bank halves
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;

  // Implemented banks, one bit per bank; the rest read zero
  localparam logic [15:0] IMPL_BANKS = 16'h803f;

  // Register locations in the special function area
  localparam logic [11:0] BANK_SEL_ADDR = 12'hfe0;
  localparam logic [11:0] PTR_BASE [NUM_PTR] = '{12'hfef, 12'hfe7, 12'hfdf};

  // Port and pointer byte offsets below each pointer's base
  localparam logic [11:0] PORT_OFS [NUM_PORT] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h004};
  localparam logic [11:0] PTR_HI_OFS = 12'h005;
  localparam logic [11:0] PTR_LO_OFS = 12'h006;

  // Port kinds, index into PORT_OFS
  localparam logic [2:0] PORT_PLAIN = 3'h0;
  localparam logic [2:0] PORT_POSTDEC = 3'h1;
  localparam logic [2:0] PORT_POSTINC = 3'h2;
  localparam logic [2:0] PORT_PREINC = 3'h3;
  localparam logic [2:0] PORT_OFFSET = 3'h4;

  // Reset values
  localparam logic [3:0] BSR_RESET = 4'h0;
  localparam logic [11:0] PTR_RESET = 12'h000;

  typedef enum logic [1:0] {
    REQ_DIRECT = 2'b00,
    REQ_FULL = 2'b01,
    REQ_LOAD_BANK = 2'b10
  } dmau_req_e;

  typedef enum logic [1:0] {
    PTR_HOLD = 2'b00,
    PTR_INC = 2'b01,
    PTR_DEC = 2'b10
  } dmau_ptr_cmd_e;

endpackage : dmau_pkg

// ==== rtl/dmau_ptr_if.sv ====
`timescale 1ns/1ps
interface dmau_ptr_if;
  dmau_pkg::dmau_ptr_cmd_e cmd;
  logic wr_hi;
  logic wr_lo;
  logic [7:0] wdata;
  logic [11:0] value;

  modport ctrl (output cmd, output wr_hi, output wr_lo, output wdata, input value);
  modport ptr (input cmd, input wr_hi, input wr_lo, input wdata, output value);
endinterface : dmau_ptr_if

// ==== rtl/dmau_ptr.sv ====
`timescale 1ns/1ps
module dmau_ptr (
  // Clock and control
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  // Pointer control
  dmau_ptr_if.ptr pif
);

  typedef struct packed {
    logic [11:0] ptr;
  } dmau_ptr_s;

  dmau_ptr_s r;
  dmau_ptr_s n;

  always_comb begin
    n = r;
    // A register write beats the auto step
    if (pif.wr_hi || pif.wr_lo) begin
      if (pif.wr_hi) begin
        n.ptr[11:8] = pif.wdata[3:0];
      end
      if (pif.wr_lo) begin
        n.ptr[7:0] = pif.wdata;
      end
    end else if (pif.cmd == dmau_pkg::PTR_INC) begin
      n.ptr = r.ptr + 12'h001;
    end else if (pif.cmd == dmau_pkg::PTR_DEC) begin
      n.ptr = r.ptr - 12'h001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      r.ptr <= dmau_pkg::PTR_RESET;
    end else if (ce) begin
      r <= n;
    end
  end

  assign pif.value = r.ptr;

endmodule : dmau_ptr

// ==== verif/dmau_ram_model.sv ====
`timescale 1ns/1ps
module dmau_ram_model (
  // Clock
  input wire logic core_clk,
  // Ram side
  input wire logic [11:0] ram_addr,
  input wire logic ram_rd_en,
  input wire logic ram_wr_en,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [4096];
  initial ram_rdata = 8'h00;
  // Idle data toggles so a late sample is never a lucky match
  always @(posedge core_clk) begin
    if (ram_wr_en) begin
      mem[ram_addr] <= ram_wdata;
    end
    if (ram_rd_en) begin
      ram_rdata <= mem[ram_addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule : dmau_ram_model

// ==== verif/dmau_top_tb_top.sv ====
`timescale 1ns/1ps
module dmau_top_tb_top;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  logic req_rd = 1'b0;
  logic req_wr = 1'b0;
  logic access_bit = 1'b0;
  logic [1:0] req_kind = 2'b00;
  logic [7:0] operand = 8'h00;
  logic [7:0] literal = 8'h00;
  logic [7:0] working_reg = 8'hfe;
  logic [7:0] wdata = 8'h00;
  logic [11:0] full_addr = 12'h000;
  logic [11:0] ram_addr;
  logic ram_rd_en;
  logic ram_wr_en;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [7:0] bank_select_reg;
  logic [11:0] addr_seen;
  logic en_seen;
  int fail_count = 0;
  int cmp_count = 0;

  always #10 core_clk = ~core_clk;

  dmau_top dut (.core_clk(core_clk), .srst(srst), .ce(ce), .req_valid(req_valid),
    .req_kind(req_kind), .req_rd(req_rd), .req_wr(req_wr), .access_bit(access_bit),
    .operand(operand), .full_addr(full_addr), .literal(literal),
    .working_reg(working_reg), .wdata(wdata), .ram_addr(ram_addr), .ram_rd_en(ram_rd_en),
    .ram_wr_en(ram_wr_en), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .rd_data(rd_data), .rd_valid(rd_valid), .bank_select_reg(bank_select_reg));

  dmau_ram_model ram (.core_clk(core_clk), .ram_addr(ram_addr), .ram_rd_en(ram_rd_en),
    .ram_wr_en(ram_wr_en), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic req(input logic [1:0] k, input logic rd, input logic wr, input logic a,
                     input logic [7:0] op, input logic [7:0] d, input logic [11:0] fa);
    @(negedge core_clk);
    req_kind = k;
    req_rd = rd;
    req_wr = wr;
    access_bit = a;
    operand = op;
    wdata = d;
    literal = d;
    full_addr = fa;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    req_rd = 1'b0;
    req_wr = 1'b0;
    en_seen = ram_rd_en | ram_wr_en;
    addr_seen = ram_addr;
  endtask : req

  task automatic rd_chk(input logic [7:0] exp);
    bit got;
    got = 0;
    for (int i = 0; i < 4 && !got; i++) begin
      @(negedge core_clk);
      if (rd_valid === 1'b1) begin
        got = 1;
        chk("rd_data", {4'h0, rd_data}, {4'h0, exp});
      end
    end
    chk("rd_valid", {11'h0, got}, 12'h001);
  endtask : rd_chk

  task automatic dwr(input logic a, input logic [7:0] op, input logic [7:0] d);
    req(dmau_pkg::REQ_DIRECT, 1'b0, 1'b1, a, op, d, 12'h000);
  endtask : dwr

  task automatic drd(input logic a, input logic [7:0] op, input logic [7:0] exp);
    req(dmau_pkg::REQ_DIRECT, 1'b1, 1'b0, a, op, 8'h00, 12'h000);
    rd_chk(exp);
  endtask : drd

  task automatic lb(input logic [7:0] d);
    req(dmau_pkg::REQ_LOAD_BANK, 1'b0, 1'b0, 1'b0, 8'h00, d, 12'h000);
  endtask : lb

  task automatic setp(input int i, input logic [7:0] hi, input logic [7:0] lo);
    dwr(1'b0, dmau_pkg::PTR_BASE[i][7:0] - 8'h05, hi);
    dwr(1'b0, dmau_pkg::PTR_BASE[i][7:0] - 8'h06, lo);
  endtask : setp

  task automatic t_access;
    logic [7:0] ops [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
    foreach (ops[i]) begin
      dwr(1'b0, ops[i], ops[i]);
      chk("acc_addr", addr_seen, ops[i][7] ? {4'hf, ops[i]} : {4'h0, ops[i]});
      chk("acc_en", {11'h0, en_seen}, 12'h001);
      drd(1'b0, ops[i], ops[i]);
    end
  endtask : t_access

  task automatic t_bank;
    lb(8'hf3);
    chk("bsr", {4'h0, bank_select_reg}, 12'h003);
    dwr(1'b1, 8'h45, 8'h5a);
    chk("bank_addr", addr_seen, 12'h345);
    drd(1'b1, 8'h45, 8'h5a);
    drd(1'b0, dmau_pkg::BANK_SEL_ADDR[7:0], 8'h03);
    // Upper nibble of the written byte must be dropped
    dwr(1'b0, dmau_pkg::BANK_SEL_ADDR[7:0], 8'hf5);
    chk("bsr_wr", {4'h0, bank_select_reg}, 12'h005);
  endtask : t_bank

  task automatic t_unimpl;
    lb(8'h06);
    dwr(1'b1, 8'h10, 8'haa);
    chk("unimpl_wr", {11'h0, en_seen}, 12'h000);
    drd(1'b1, 8'h10, 8'h00);
    req(dmau_pkg::REQ_FULL, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 12'h345);
    chk("full_addr", addr_seen, 12'h345);
    rd_chk(8'h5a);
  endtask : t_unimpl

  task automatic t_ptr;
    logic [2:0] port [8] = '{3'h0, 3'h2, 3'h0, 3'h1, 3'h0, 3'h3, 3'h4, 3'h0};
    logic [11:0] exp [8] = '{12'h1ff, 12'h1ff, 12'h200, 12'h200, 12'h1ff, 12'h200,
                             12'h1fe, 12'h200};
    for (int i = 0; i < 3; i++) begin
      setp(i, 8'h01, 8'h10 + 8'(i));
      dwr(1'b0, dmau_pkg::PTR_BASE[i][7:0], 8'h00);
      chk("ptr_addr", addr_seen, 12'h110 + 12'(i));
    end
    setp(0, 8'h01, 8'hff);
    foreach (port[i]) begin
      dwr(1'b0, dmau_pkg::PTR_BASE[0][7:0] - 8'(port[i]), 8'h00);
      chk("port_addr", addr_seen, exp[i]);
    end
    drd(1'b0, dmau_pkg::PTR_BASE[0][7:0] - 8'h06, 8'h00);
    drd(1'b0, dmau_pkg::PTR_BASE[0][7:0] - 8'h05, 8'h02);
  endtask : t_ptr

  task automatic t_self;
    setp(0, 8'h0f, dmau_pkg::PTR_BASE[0][7:0]);
    dwr(1'b0, dmau_pkg::PTR_BASE[0][7:0], 8'h11);
    chk("self_wr", {11'h0, en_seen}, 12'h000);
    drd(1'b0, dmau_pkg::PTR_BASE[0][7:0], 8'h00);
    chk("self_rd", {11'h0, en_seen}, 12'h000);
  endtask : t_self

  // Frozen clock enable, then a reset in mid-run
  task automatic t_ce_rst;
    @(negedge core_clk);
    ce = 1'b0;
    lb(8'h01);
    chk("ce_hold", {4'h0, bank_select_reg}, 12'h006);
    ce = 1'b1;
    srst = 1'b1;
    @(negedge core_clk);
    srst = 1'b0;
    chk("bsr_rst2", {4'h0, bank_select_reg}, 12'h000);
    drd(1'b0, dmau_pkg::PTR_BASE[0][7:0] - 8'h06, 8'h00);
  endtask : t_ce_rst

  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Whole run is about 120 cycles; allow ample margin
  initial begin
    #40000;
    fail_count++;
    finish_test();
  end

  initial begin
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    chk("bsr_reset", {4'h0, bank_select_reg}, 12'h000);
    t_access();
    t_bank();
    t_unimpl();
    t_ptr();
    t_self();
    t_ce_rst();
    finish_test();
  end
endmodule : dmau_top_tb_top
